// ---- safety_output_pkg.sv ----
// Shared constants and types for the safety output restart logic
package safety_output_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_PERIOD_NS  = 1000000;
   localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FILTER_NS       = 160;
   localparam int FILTER_CYCLES   = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELAY_EXT_MS    = 12;
   localparam int TICK_MS         = 1;
   localparam logic [3:0] RELAY_TICKS = 4'(RELAY_EXT_MS / TICK_MS);

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int CHANNELS        = 4;
   localparam int FIELD_INPUTS    = 8;
   localparam int STATUS_OUTPUTS  = 4;
   localparam int TEST_OUTPUTS    = 2;
   localparam int FILT_WIDTH      = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Filtered input vector positions
   localparam int FI_ENABLE_A     = 0;
   localparam int FI_ENABLE_B     = 1;
   localparam int FI_ADDR_LOW     = 2;
   localparam int FI_ADDR_HIGH    = 3;
   localparam int FI_FBK          = 4;
   localparam int FI_READBACK     = 8;
   localparam int FI_RELAY        = 12;
   localparam int FI_FIELD        = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL        = 8'h00;
   localparam logic [7:0] ADDR_MODE        = 8'h04;
   localparam logic [7:0] ADDR_LOGIC_REQ   = 8'h08;
   localparam logic [7:0] ADDR_RELAY_EN    = 8'h0C;
   localparam logic [7:0] ADDR_TEST_EN     = 8'h10;
   localparam logic [7:0] ADDR_STATUS_SEL  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;
   localparam logic [7:0] ADDR_STATE       = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Field layouts and encodings
   localparam int IRQ_BITS        = 10;
   localparam int IRQ_OUT_FAULT   = 0;
   localparam int IRQ_RELAY_FAULT = 4;
   localparam int IRQ_TEST_FAULT  = 8;
   localparam int IRQ_DISABLED    = 9;

   localparam logic [1:0] MODE_AUTO      = 2'h0;
   localparam logic [1:0] MODE_MANUAL    = 2'h1;
   localparam logic [1:0] MODE_MONITORED = 2'h2;

   localparam logic [1:0] GROUP_SINGLES  = 2'h0;
   localparam logic [1:0] GROUP_DUALS    = 2'h1;
   localparam logic [1:0] GROUP_MIXED    = 2'h2;

   localparam logic [1:0] SRC_INPUT      = 2'h0;
   localparam logic [1:0] SRC_OUTPUT     = 2'h1;
   localparam logic [1:0] SRC_NODE       = 2'h2;

   localparam logic [2:0] CTRL_RESET     = 3'h0;
   localparam logic [7:0] MODE_RESET     = 8'h00;

   typedef struct packed {
      logic [1:0] group;
      logic       extended;
   } ctrl_t;

   typedef struct packed {
      logic [1:0] src;
      logic [2:0] idx;
   } status_sel_t;

endpackage

// ---- input_filter.sv ----
// Two-flop synchroniser and stability filter for slow field inputs
module input_filter #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] raw_i,
   output logic      [WIDTH-1:0] clean_o
);

   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= raw_i;
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Level taken once stable for the filter time
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic [4:0] cnt_r;
         wire        differs = sync2_r[g] != clean_o[g];
         wire        settled = cnt_r == 5'(safety_output_pkg::FILTER_CYCLES - 1);

         always_ff @(posedge core_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
            begin
               cnt_r      <= 5'h00;
               clean_o[g] <= 1'b0;
            end
            else if (!differs)
               cnt_r <= 5'h00;
            else if (settled)
            begin
               cnt_r      <= 5'h00;
               clean_o[g] <= sync2_r[g];
            end
            else
               cnt_r <= cnt_r + 5'h01;
         end
      end
   endgenerate

endmodule

// ---- restart_channel.sv ----
// Restart sequencer for one safety output channel
module restart_channel (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       demand_i,
   input  wire logic       fbk_i,
   output logic            permit_o
);

   typedef enum logic [1:0] {WAIT, HIGH_SEEN, RUN} state_t;

   state_t state_r;
   state_t state_nxt;
   logic   fbk_d_r;

   wire rise = fbk_i & ~fbk_d_r;
   wire fall = ~fbk_i & fbk_d_r;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         WAIT:
         begin
            if (demand_i && rise && mode_i == safety_output_pkg::MODE_MANUAL)
               state_nxt = RUN;
            else if (demand_i && rise && mode_i == safety_output_pkg::MODE_MONITORED)
               state_nxt = HIGH_SEEN;
         end
         HIGH_SEEN:
         begin
            if (!demand_i)
               state_nxt = WAIT;
            else if (fall)
               state_nxt = RUN;
         end
         RUN:
         begin
            if (!demand_i)
               state_nxt = WAIT;
         end
         default:
            state_nxt = WAIT;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r <= WAIT;
         fbk_d_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         fbk_d_r <= fbk_i;
      end
   end

   // Automatic mode follows the feedback level, no latching
   assign permit_o = (mode_i == safety_output_pkg::MODE_AUTO) ? (demand_i & fbk_i)
                   : (state_r == RUN) & demand_i;

endmodule

// ---- safety_output_restart_logic.sv ----
// Top of the safety output, restart and supervision logic
module safety_output_restart_logic #(
   parameter int TICK_CYCLES = safety_output_pkg::TICK_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic        unit_enable_a_i,
   input  wire logic        unit_enable_b_i,
   input  wire logic        addr_select_low_i,
   input  wire logic        addr_select_high_i,
   input  wire logic [3:0]  restart_fbk_i,
   input  wire logic [3:0]  output_readback_i,
   input  wire logic [3:0]  relay_fbk_i,
   input  wire logic [7:0]  field_input_i,
   input  wire logic [7:0]  logic_node_i,
   output logic      [3:0]  safety_switch_output_o,
   output logic      [3:0]  status_out_o,
   output logic      [1:0]  test_out_o,
   output logic      [1:0]  node_addr_o,
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Input conditioning
   logic [23:0] filt;

   input_filter #(
      .WIDTH (safety_output_pkg::FILT_WIDTH)
   ) u_filter (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .raw_i      ({field_input_i, relay_fbk_i, output_readback_i, restart_fbk_i,
                    addr_select_high_i, addr_select_low_i, unit_enable_b_i, unit_enable_a_i}),
      .clean_o    (filt)
   );

   wire       en_a     = filt[safety_output_pkg::FI_ENABLE_A];
   wire       en_b     = filt[safety_output_pkg::FI_ENABLE_B];
   wire [3:0] fbk      = filt[safety_output_pkg::FI_FBK +: 4];
   wire [3:0] readback = filt[safety_output_pkg::FI_READBACK +: 4];
   wire [3:0] relay_nc = filt[safety_output_pkg::FI_RELAY +: 4];
   wire [7:0] field    = filt[safety_output_pkg::FI_FIELD +: 8];

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   safety_output_pkg::ctrl_t       ctrl_r;
   logic [7:0]                     mode_r;
   logic [3:0]                     logic_req_r;
   logic [3:0]                     relay_en_r;
   logic [7:0]                     test_en_r;
   safety_output_pkg::status_sel_t sel_r [4];
   logic [9:0]                     irq_st_r;
   logic [9:0]                     irq_st_nxt;
   logic [9:0]                     irq_mask_r;
   logic [9:0]                     irq_set;
   logic [3:0]                     out_r;
   logic [3:0]                     out_nxt;

   wire wr_ctrl   = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_CTRL;
   wire wr_mode   = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_MODE;
   wire wr_req    = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_LOGIC_REQ;
   wire wr_relay  = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_RELAY_EN;
   wire wr_test   = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_TEST_EN;
   wire wr_sel    = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_STATUS_SEL;
   wire wr_irq_st = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_IRQ_STATUS;
   wire wr_mask   = reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_IRQ_MASK;

   // Extended variant has no enable pins at all
   wire enabled = ctrl_r.extended | (en_a & en_b);

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_r      <= safety_output_pkg::ctrl_t'(safety_output_pkg::CTRL_RESET);
         mode_r      <= safety_output_pkg::MODE_RESET;
         logic_req_r <= 4'h0;
         relay_en_r  <= 4'h0;
         test_en_r   <= 8'h00;
         irq_mask_r  <= 10'h000;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= safety_output_pkg::ctrl_t'(reg_wdata_i[2:0]);
         if (wr_mode)
            mode_r <= reg_wdata_i[7:0];
         if (wr_req)
            logic_req_r <= reg_wdata_i[3:0];
         if (wr_relay)
            relay_en_r <= reg_wdata_i[3:0];
         if (wr_test)
            test_en_r <= reg_wdata_i[7:0];
         if (wr_mask)
            irq_mask_r <= reg_wdata_i[9:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond tick
   logic [16:0] tick_cnt_r;
   logic        tick_r;

   wire tick_wrap = tick_cnt_r == 17'(TICK_CYCLES - 1);

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tick_cnt_r <= 17'h00000;
         tick_r     <= 1'b0;
      end
      else
      begin
         tick_cnt_r <= tick_wrap ? 17'h00000 : tick_cnt_r + 17'h00001;
         tick_r     <= tick_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel grouping and restart sequencing
   wire [3:0] chan_fault = irq_st_r[safety_output_pkg::IRQ_OUT_FAULT +: 4]
                         | irq_st_r[safety_output_pkg::IRQ_RELAY_FAULT +: 4];
   wire       follow1    = ctrl_r.group == safety_output_pkg::GROUP_DUALS
                         || ctrl_r.group == safety_output_pkg::GROUP_MIXED;
   wire       follow3    = ctrl_r.group == safety_output_pkg::GROUP_DUALS;
   wire [3:0] follow     = {follow3, 1'b0, follow1, 1'b0};
   // A fault on either leg of a pair drops the whole pair
   wire [3:0] pair_fault = chan_fault | {1'b0, follow3 & chan_fault[3], 1'b0, follow1 & chan_fault[1]};
   // Odd channels may copy their lead
   logic [3:0] permit;
   logic [3:0] dem;

   genvar c;
   generate
      for (c = 0; c < safety_output_pkg::CHANNELS; c++)
      begin : g_chan
         assign dem[c] = logic_req_r[c] & ~pair_fault[c] & enabled;

         restart_channel u_restart (
            .core_clk_i (core_clk_i),
            .reset_n_i  (reset_n_i),
            .mode_i     (mode_r[2*c +: 2]),
            .demand_i   (dem[c]),
            .fbk_i      (fbk[c]),
            .permit_o   (permit[c])
         );

         if (c % 2 == 1)
         begin : g_odd
            assign out_nxt[c] = follow[c] ? permit[c-1] : permit[c];
         end
         else
         begin : g_even
            assign out_nxt[c] = permit[c];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Output readback and relay supervision
   logic [3:0] out_tick_r;
   logic [3:0] relay_cnt_r [4];

   generate
      for (c = 0; c < safety_output_pkg::CHANNELS; c++)
      begin : g_sup
         // Tick check with output steady rides out filter lag
         assign irq_set[safety_output_pkg::IRQ_OUT_FAULT + c] =
            tick_r && out_r[c] == out_tick_r[c] && readback[c] != out_r[c];
         // NC contact must oppose the drive after the window
         assign irq_set[safety_output_pkg::IRQ_RELAY_FAULT + c] =
            tick_r && relay_en_r[c] && relay_cnt_r[c] == 4'h0 && relay_nc[c] == out_r[c];

         always_ff @(posedge core_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
               relay_cnt_r[c] <= 4'h0;
            else if (out_nxt[c] != out_r[c])
               relay_cnt_r[c] <= safety_output_pkg::RELAY_TICKS;
            else if (tick_r && relay_cnt_r[c] != 4'h0)
               relay_cnt_r[c] <= relay_cnt_r[c] - 4'h1;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Input wiring test pattern
   logic [1:0] test_r;
   logic [7:0] test_level;

   generate
      for (c = 0; c < safety_output_pkg::FIELD_INPUTS; c++)
      begin : g_test
         assign test_level[c] = test_r[c % safety_output_pkg::TEST_OUTPUTS];
      end
   endgenerate

   // Tested input must match its test output
   assign irq_set[safety_output_pkg::IRQ_TEST_FAULT] = tick_r && |(test_en_r & (field ^ test_level));

   logic enabled_d_r;
   assign irq_set[safety_output_pkg::IRQ_DISABLED] = enabled_d_r & ~enabled;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, set wins over write-one-to-clear
   wire [9:0] irq_clr = wr_irq_st ? reg_wdata_i[9:0] : 10'h000;
   assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;

   ////////////////////////////////////////////////////////////////////////////
   // Status output selection
   logic [3:0] status_nxt;

   generate
      for (c = 0; c < safety_output_pkg::STATUS_OUTPUTS; c++)
      begin : g_status
         assign status_nxt[c] =
            sel_r[c].src == safety_output_pkg::SRC_INPUT  ? field[sel_r[c].idx] :
            sel_r[c].src == safety_output_pkg::SRC_OUTPUT ? out_r[sel_r[c].idx[1:0]] :
            sel_r[c].src == safety_output_pkg::SRC_NODE   ? logic_node_i[sel_r[c].idx] : 1'b0;

         always_ff @(posedge core_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
               sel_r[c] <= '0;
            else if (wr_sel)
               sel_r[c] <= safety_output_pkg::status_sel_t'(reg_wdata_i[8*c +: 5]);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   wire [1:0]  node_nxt = {filt[safety_output_pkg::FI_ADDR_HIGH], filt[safety_output_pkg::FI_ADDR_LOW]};
   wire [31:0] rd_mux =
      reg_addr_i == safety_output_pkg::ADDR_CTRL       ? {29'h0, ctrl_r} :
      reg_addr_i == safety_output_pkg::ADDR_MODE       ? {24'h0, mode_r} :
      reg_addr_i == safety_output_pkg::ADDR_LOGIC_REQ  ? {28'h0, logic_req_r} :
      reg_addr_i == safety_output_pkg::ADDR_RELAY_EN   ? {28'h0, relay_en_r} :
      reg_addr_i == safety_output_pkg::ADDR_TEST_EN    ? {24'h0, test_en_r} :
      reg_addr_i == safety_output_pkg::ADDR_STATUS_SEL ? {3'h0, sel_r[3], 3'h0, sel_r[2], 3'h0, sel_r[1],
                                                          3'h0, sel_r[0]} :
      reg_addr_i == safety_output_pkg::ADDR_IRQ_STATUS ? {22'h0, irq_st_r} :
      reg_addr_i == safety_output_pkg::ADDR_IRQ_MASK   ? {22'h0, irq_mask_r} :
      reg_addr_i == safety_output_pkg::ADDR_STATE      ? {21'h0, fbk, enabled, node_addr_o, out_r} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Output flops
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         out_r       <= 4'h0;
         out_tick_r  <= 4'h0;
         test_r      <= 2'h1;
         irq_st_r    <= 10'h000;
         enabled_d_r <= 1'b0;
         irq_o       <= 1'b0;
         reg_rdata_o <= 32'h0;
         node_addr_o <= 2'h0;
         status_out_o <= 4'h0;
      end
      else
      begin
         out_r        <= out_nxt & {4{enabled}};
         irq_st_r     <= irq_st_nxt;
         enabled_d_r  <= enabled;
         irq_o        <= |(irq_st_nxt & irq_mask_r);
         reg_rdata_o  <= reg_rd_i ? rd_mux : 32'h0;
         node_addr_o  <= node_nxt;
         status_out_o <= status_nxt;
         if (tick_r)
         begin
            out_tick_r <= out_r;
            test_r     <= ~test_r;
         end
      end
   end

   assign safety_switch_output_o = out_r;
   assign test_out_o             = test_r;

endmodule

// ---- safety_output_restart_logic_assertions.sv ----
// Port-level checks for the safety output restart logic
module safety_output_restart_logic_assertions (
   input wire logic        core_clk_i,
   input wire logic        reset_n_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        unit_enable_a_i,
   input wire logic        unit_enable_b_i,
   input wire logic        addr_select_low_i,
   input wire logic        addr_select_high_i,
   input wire logic [3:0]  restart_fbk_i,
   input wire logic [3:0]  safety_switch_output_o,
   input wire logic [1:0]  test_out_o,
   input wire logic [1:0]  node_addr_o
);
   logic [5:0] off_cnt_r, sel_cnt_r, hi_cnt_r, lo_cnt_r;
   logic [1:0] sel_d_r, mode0_r;
   logic       ext_r;
   wire  [1:0] sel = {addr_select_high_i, addr_select_low_i};
   wire        fbk = restart_fbk_i[0];
   ////////////////////////////////////////////////////////////////////////////
   // Saturating quiet-time counters; the pin filter makes raw edges lag
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         {off_cnt_r, sel_cnt_r, hi_cnt_r, lo_cnt_r, sel_d_r} <= '0;
      else
      begin
         off_cnt_r <= (unit_enable_a_i & unit_enable_b_i) ? 6'h0 : off_cnt_r + 6'(~&off_cnt_r);
         sel_cnt_r <= (sel != sel_d_r) ? 6'h0 : sel_cnt_r + 6'(~&sel_cnt_r);
         hi_cnt_r  <= !fbk ? 6'h0 : hi_cnt_r + 6'(~&hi_cnt_r);
         lo_cnt_r  <= fbk ? 6'h0 : lo_cnt_r + 6'(~&lo_cnt_r);
         sel_d_r   <= sel;
      end
   end
   // Shadow of the configuration that channel 0 obeys
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         {ext_r, mode0_r} <= '0;
      else if (reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_CTRL)
         ext_r <= reg_wdata_i[0];
      else if (reg_wr_i && reg_addr_i == safety_output_pkg::ADDR_MODE)
         mode0_r <= reg_wdata_i[1:0];
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_out0_rise;
      $rose(safety_switch_output_o[0]);
   endsequence
   a_disable_forces_off: assert property ((off_cnt_r >= 6'h18 && !ext_r) |-> safety_switch_output_o == 4'h0)
      else $error("outputs on while disabled");
   a_node_follows_sel: assert property (sel_cnt_r >= 6'h18 |-> node_addr_o == sel_d_r)
      else $error("node address mismatch");
   a_auto_needs_fbk: assert property (s_out0_rise ##0 (mode0_r == safety_output_pkg::MODE_AUTO) |-> hi_cnt_r >= 6'h10)
      else $error("auto on without feedback");
   a_auto_fbk_low: assert property ((mode0_r == safety_output_pkg::MODE_AUTO && lo_cnt_r >= 6'h18)
      |-> !safety_switch_output_o[0])
      else $error("auto on with feedback low");
   a_manual_rise_edge: assert property (s_out0_rise ##0 (mode0_r == safety_output_pkg::MODE_MANUAL)
      |-> hi_cnt_r inside {[6'h10:6'h28]})
      else $error("manual on without rise");
   a_monitor_full_pulse: assert property (s_out0_rise ##0 (mode0_r == safety_output_pkg::MODE_MONITORED)
      |-> lo_cnt_r inside {[6'h10:6'h28]})
      else $error("monitored on without pulse");
   a_test_out_hold: assert property ($changed(test_out_o) |=> $stable(test_out_o) [*8])
      else $error("test output toggled early");
   a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data without read");
endmodule

// ---- field_wiring_model.sv ----
// Field wiring model: output pins, relay contacts and tested input lines
module field_wiring_model #(
   parameter int RELAY_DLY = 3
) (
   input  wire logic       core_clk_i,
   input  wire logic [3:0] out_i,
   input  wire logic [1:0] test_i,
   input  wire logic [3:0] pin_short_i,
   input  wire logic [3:0] relay_stuck_i,
   input  wire logic [7:0] line_short_i,
   output logic      [3:0] readback_o,
   output logic      [3:0] relay_nc_o,
   output logic      [7:0] field_o
);
   logic [3:0] coil_q [RELAY_DLY];
   // Armature lags the coil; a stuck relay keeps its NC contact closed
   always @(posedge core_clk_i)
   begin
      coil_q[0] <= out_i;
      for (int k = 1; k < RELAY_DLY; k++)
         coil_q[k] <= coil_q[k-1];
   end
   assign relay_nc_o = ~coil_q[RELAY_DLY-1] | relay_stuck_i;
   assign readback_o = out_i & ~pin_short_i;
   always_comb
      for (int i = 0; i < 8; i++)
         field_o[i] = test_i[i % 2] & ~line_short_i[i];
endmodule

// ---- tb_safety_output_restart_logic.sv ----
// Self-checking bench for the safety output restart logic
module tb_safety_output_restart_logic;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICKS = 20;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        en_a = 1'b0;
   logic        en_b = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [3:0]  fbk = 4'h0;
   logic [7:0]  node = 8'h00;
   logic [3:0]  pin_short = 4'h0;
   logic [3:0]  relay_stuck = 4'h0;
   logic [7:0]  line_short = 8'h00;
   logic [31:0] reg_rdata, rv;
   logic [3:0]  readback, relay_nc, outs, status, f, e;
   logic [7:0]  field;
   logic [1:0]  test, naddr;
   logic        irq;
   int          n_errors = 0;
   int          tests_run = 0;
   int          mw, g;
   int          mode_q[$];
   always #5 core_clk = ~core_clk;
   safety_output_restart_logic #(.TICK_CYCLES(TICKS)) safety_output_restart_logic_i (
      .core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .unit_enable_a_i(en_a),
      .unit_enable_b_i(en_b), .addr_select_low_i(sel[0]), .addr_select_high_i(sel[1]),
      .restart_fbk_i(fbk), .output_readback_i(readback), .relay_fbk_i(relay_nc), .field_input_i(field),
      .logic_node_i(node), .safety_switch_output_o(outs), .status_out_o(status), .test_out_o(test),
      .node_addr_o(naddr), .irq_o(irq));
   field_wiring_model field_wiring_model_i (
      .core_clk_i(core_clk), .out_i(outs), .test_i(test), .pin_short_i(pin_short),
      .relay_stuck_i(relay_stuck), .line_short_i(line_short), .readback_o(readback),
      .relay_nc_o(relay_nc), .field_o(field));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Model: feedback high, low, high, low
   function automatic logic exp_out(input int m, input int s);
      case (m)
         0: return s % 2 == 0;
         1: return 1'b1;
         2: return s >= 1;
         default: return 1'b0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      step(100000);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(32'h7DF98074));
      step(4);
      reset_n <= 1'b1;
      step(1);
      chk("test out reset", 32'h1, 32'(test));
      wr(8'h20, 32'hFFFFFFFF);
      wr(8'h24, 32'hFFFFFFFF);
      for (int a = 0; a <= 'h24; a += 4)
      begin
         rd(8'(a));
         chk("reset register", 32'h0, rv);
      end
      // Single unit on the bus, so its address is unique
      for (int n = 0; n < 4; n++)
      begin
         sel <= 2'(n);
         step(30);
         chk("node address", 32'(n), 32'(naddr));
      end
      en_a <= 1'b1;
      en_b <= 1'b1;
      repeat (3)
      begin
         mode_q.delete();
         mw = 0;
         for (int c = 0; c < 4; c++)
         begin
            mode_q.push_back($urandom_range(3));
            mw |= mode_q[c] << (2 * c);
         end
         wr(8'h04, 32'(mw));
         fbk <= 4'h0;
         step(30);
         wr(8'h08, 32'hF);
         for (int s = 0; s < 4; s++)
         begin
            fbk <= s[0] ? 4'h0 : 4'hF;
            step(30);
            for (int c = 0; c < 4; c++)
               e[c] = exp_out(mode_q[c], s);
            chk("restart", 32'(e), 32'(outs));
         end
         wr(8'h08, 32'h0);
      end
      wr(8'h04, 32'h0);
      wr(8'h08, 32'hF);
      wr(8'h1C, 32'h200);
      fbk <= 4'hF;
      en_b <= 1'b0;
      step(30);
      chk("disabled", 32'h0, 32'(outs));
      chk("disable irq", 32'h1, 32'(irq));
      rd(8'h18);
      chk("enable lost", 32'h200, rv);
      wr(8'h18, 32'h200);
      step(2);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(8'h00, 32'h1);
      step(5);
      chk("extended", 32'hF, 32'(outs));
      en_b <= 1'b1;
      step(30);
      for (int k = 0; k < 6; k++)
      begin
         g = k % 3;
         f = 4'($urandom);
         e = (g == safety_output_pkg::GROUP_DUALS) ? {{2{f[2]}}, {2{f[0]}}} :
             (g == safety_output_pkg::GROUP_MIXED) ? {f[3:2], {2{f[0]}}} : f;
         wr(8'h00, 32'(g << 1));
         fbk <= f;
         step(30);
         chk("grouping", 32'(e), 32'(outs));
      end
      wr(8'h00, 32'h0);
      fbk <= 4'hF;
      pin_short <= 4'h1;
      step(5 * TICKS);
      rd(8'h18);
      chk("output fault", 32'h1, rv);
      chk("fault drop", 32'hE, 32'(outs));
      chk("masked irq", 32'h0, 32'(irq));
      pin_short <= 4'h0;
      wr(8'h18, 32'h1);
      step(30);
      chk("fault cleared", 32'hF, 32'(outs));
      wr(8'h0C, 32'h2);
      wr(8'h08, 32'hD);
      step(30);
      wr(8'h08, 32'hF);
      relay_stuck <= 4'h2;
      step(9 * TICKS);
      rd(8'h18);
      chk("relay settling", 32'h0, rv);
      step(6 * TICKS);
      rd(8'h18);
      chk("relay fault", 32'h20, rv);
      relay_stuck <= 4'h0;
      wr(8'h18, 32'h20);
      wr(8'h10, 32'h8);
      step(3 * TICKS);
      rd(8'h18);
      chk("healthy line", 32'h0, rv);
      line_short <= 8'h08;
      wr(8'h1C, 32'h100);
      step(3 * TICKS);
      chk("line fault irq", 32'h1, 32'(irq));
      rd(8'h18);
      chk("line fault", 32'h100, rv);
      wr(8'h10, 32'h0);
      wr(8'h18, 32'h100);
      step(2);
      chk("irq released", 32'h0, 32'(irq));
      wr(8'h14, 32'h18150903);
      repeat (4)
      begin
         node <= 8'($urandom);
         step(3);
         chk("status mirror", 32'({1'b0, node[5], 1'b1, 1'b0}), 32'(status));
      end
      give_verdict();
   end
endmodule
bind safety_output_restart_logic safety_output_restart_logic_assertions checks_i (.*);
